// ### inc/sfh_pkg.sv
// Functional notes
// - Read 5Ah starts at zero; signature SFDP.
// - Byte 04h returns minor revision 08h.
// - Byte 05h returns major revision 01h.
// - Byte 06h returns 01h, two headers.
// - Byte 07h returns access protocol FFh.
// - Byte 08h returns basic table ID 00h.
// - Byte 09h returns table minor 07h.
// - Byte 0Ah returns table major 01h.
// - Byte 0Bh returns length 10h dwords.
// - Bytes 0Ch-0Eh return pointer 30h,00h,00h.
// - Byte 0Fh returns ID high byte FFh.
// - Byte 10h returns the maker ID code.
// - Byte 11h returns vendor minor 00h.
// - Byte 12h returns vendor major 01h.
// - Byte 13h returns vendor length 03h.
// - Bytes 14h-17h return 70h,00h,00h,FFh.
// - Space is read-only; writes change nothing.
package sfh_pkg;

  // Link framing
  localparam logic [7:0] CMD_READ_SFDP = 8'h5A;
  localparam int CMD_BITS = 8;
  localparam int ADDR_BITS = 24;
  localparam int DUMMY_BITS = 8;
  localparam int BYTE_BITS = 8;
  localparam logic [5:0] CNT_CMD_LAST = 6'h07;
  localparam logic [5:0] CNT_ADDR_LAST = 6'h1F;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Header byte addresses
  localparam logic [23:0] OFS_SIG0 = 24'h00_0000;
  localparam logic [23:0] OFS_SIG1 = 24'h00_0001;
  localparam logic [23:0] OFS_SIG2 = 24'h00_0002;
  localparam logic [23:0] OFS_SIG3 = 24'h00_0003;
  localparam logic [23:0] OFS_REV_MINOR = 24'h00_0004;
  localparam logic [23:0] OFS_REV_MAJOR = 24'h00_0005;
  localparam logic [23:0] OFS_NUM_HDR = 24'h00_0006;
  localparam logic [23:0] OFS_ACCESS = 24'h00_0007;
  localparam logic [23:0] OFS_P0_ID_LSB = 24'h00_0008;
  localparam logic [23:0] OFS_P0_MINOR = 24'h00_0009;
  localparam logic [23:0] OFS_P0_MAJOR = 24'h00_000A;
  localparam logic [23:0] OFS_P0_LEN = 24'h00_000B;
  localparam logic [23:0] OFS_P0_PTR0 = 24'h00_000C;
  localparam logic [23:0] OFS_P0_PTR1 = 24'h00_000D;
  localparam logic [23:0] OFS_P0_PTR2 = 24'h00_000E;
  localparam logic [23:0] OFS_P0_ID_MSB = 24'h00_000F;
  localparam logic [23:0] OFS_P1_ID = 24'h00_0010;
  localparam logic [23:0] OFS_P1_MINOR = 24'h00_0011;
  localparam logic [23:0] OFS_P1_MAJOR = 24'h00_0012;
  localparam logic [23:0] OFS_P1_LEN = 24'h00_0013;
  localparam logic [23:0] OFS_P1_PTR0 = 24'h00_0014;
  localparam logic [23:0] OFS_P1_PTR1 = 24'h00_0015;
  localparam logic [23:0] OFS_P1_PTR2 = 24'h00_0016;
  localparam logic [23:0] OFS_P1_UNUSED = 24'h00_0017;
  localparam logic [23:0] OFS_HDR_LAST = 24'h00_0017;

  // Header byte values
  localparam logic [7:0] SIG_S = 8'h53;
  localparam logic [7:0] SIG_F = 8'h46;
  localparam logic [7:0] SIG_D = 8'h44;
  localparam logic [7:0] SIG_P = 8'h50;
  localparam logic [7:0] REV_MINOR = 8'h08;
  localparam logic [7:0] REV_MAJOR = 8'h01;
  localparam logic [7:0] NUM_HDR_M1 = 8'h01;
  localparam logic [7:0] ACCESS_PROT = 8'hFF;
  localparam logic [7:0] P0_ID_LSB = 8'h00;
  localparam logic [7:0] P0_MINOR = 8'h07;
  localparam logic [7:0] P0_MAJOR = 8'h01;
  localparam logic [7:0] P0_LEN_DW = 8'h10;
  localparam logic [7:0] P0_PTR0 = 8'h30;
  localparam logic [7:0] P0_PTR1 = 8'h00;
  localparam logic [7:0] P0_PTR2 = 8'h00;
  localparam logic [7:0] P0_ID_MSB = 8'hFF;
  localparam logic [7:0] P1_MINOR = 8'h00;
  localparam logic [7:0] P1_MAJOR = 8'h01;
  localparam logic [7:0] P1_LEN_M1 = 8'h03;
  localparam logic [7:0] P1_PTR0 = 8'h70;
  localparam logic [7:0] P1_PTR1 = 8'h00;
  localparam logic [7:0] P1_PTR2 = 8'h00;
  localparam logic [7:0] P1_UNUSED = 8'hFF;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;
  // Arbitrary neutral maker code, replace per product
  localparam logic [7:0] VENDOR_ID_DEF = 8'hA5;

  // Buffer shape
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  // Link states
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA = 3'b011,
    ST_IGNORE = 3'b100
  } sfh_state_e;

  // Events reported to the system side
  typedef struct packed {
    logic read_start;
    logic cmd_ignored;
    logic [23:0] start_addr;
  } sfh_event_s;

  // Constant header contents; bytes past the header read blank
  function automatic logic [7:0] sfh_rom_byte(input logic [23:0] a, input logic [7:0] vid);
    logic [7:0] d;
    d = BLANK_BYTE;
    case (a)
      OFS_SIG0: d = SIG_S;
      OFS_SIG1: d = SIG_F;
      OFS_SIG2: d = SIG_D;
      OFS_SIG3: d = SIG_P;
      OFS_REV_MINOR: d = REV_MINOR;
      OFS_REV_MAJOR: d = REV_MAJOR;
      OFS_NUM_HDR: d = NUM_HDR_M1;
      OFS_ACCESS: d = ACCESS_PROT;
      OFS_P0_ID_LSB: d = P0_ID_LSB;
      OFS_P0_MINOR: d = P0_MINOR;
      OFS_P0_MAJOR: d = P0_MAJOR;
      OFS_P0_LEN: d = P0_LEN_DW;
      OFS_P0_PTR0: d = P0_PTR0;
      OFS_P0_PTR1: d = P0_PTR1;
      OFS_P0_PTR2: d = P0_PTR2;
      OFS_P0_ID_MSB: d = P0_ID_MSB;
      OFS_P1_ID: d = vid;
      OFS_P1_MINOR: d = P1_MINOR;
      OFS_P1_MAJOR: d = P1_MAJOR;
      OFS_P1_LEN: d = P1_LEN_M1;
      OFS_P1_PTR0: d = P1_PTR0;
      OFS_P1_PTR1: d = P1_PTR1;
      OFS_P1_PTR2: d = P1_PTR2;
      OFS_P1_UNUSED: d = P1_UNUSED;
      default: d = BLANK_BYTE;
    endcase
    return d;
  endfunction

endpackage

// ### rtl/sfh_fifo.sv
`timescale 1ns/1ps
module sfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sfh_fifo_s;

  sfh_fifo_s st_reg;
  sfh_fifo_s st_next;
  logic push;
  logic pop;

  // Full and empty follow the occupancy count
  assign in_ready = (st_reg.cnt != (PW+1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer wrap handles depths that are not powers of two
  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = (st_reg.wp == PW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
    end
    if (pop)
      st_next.rp = (st_reg.rp == PW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
    if (push && !pop)
      st_next.cnt = st_reg.cnt + 1'b1;
    else if (pop && !push)
      st_next.cnt = st_reg.cnt - 1'b1;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule

// ### rtl/sfh_rom.sv
`timescale 1ns/1ps
module sfh_rom #(
  parameter logic [7:0] VENDOR_ID = sfh_pkg::VENDOR_ID_DEF,
  parameter int DUMMY = sfh_pkg::DUMMY_BITS,
  parameter int FWIDTH = sfh_pkg::FIFO_WIDTH,
  parameter int FDEPTH = sfh_pkg::FIFO_DEPTH
) (
  // System clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  output logic link_miso,
  output logic link_miso_oe,
  // System side status
  output logic read_active,
  output logic read_start,
  output logic cmd_ignored,
  output logic [23:0] start_addr,
  output logic [15:0] read_count
);
  import sfh_pkg::*;

  localparam logic [5:0] CNT_DUMMY_LAST = 6'(CMD_BITS + ADDR_BITS + DUMMY - 1);

  // Frame state on the link clock, cleared whenever select is high
  typedef struct packed {
    sfh_state_e st;
    logic [5:0] cnt;
    logic [7:0] cmd;
    logic [23:0] addr;
    logic [23:0] rd_addr;
    logic rd_go;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic miso;
    logic oe;
  } sfh_link_s;

  // Event toggles on the link clock, survive frame ends
  typedef struct packed {
    logic tgl_read;
    logic tgl_ign;
    logic [23:0] hold_addr;
  } sfh_ltgl_s;

  // System side synchronisers and outputs
  typedef struct packed {
    logic [2:0] cs_sync;
    logic [2:0] rd_sync;
    logic [2:0] ign_sync;
    logic active;
    logic start;
    logic ign;
    logic [23:0] addr;
    logic [15:0] count;
  } sfh_sys_s;

  sfh_link_s lk_reg;
  sfh_link_s lk_next;
  sfh_ltgl_s tg_reg;
  sfh_ltgl_s tg_next;
  sfh_sys_s sy_reg;
  sfh_sys_s sy_next;
  sfh_event_s ev;

  logic frame_rst;
  logic [7:0] cmd_full;
  logic [7:0] rom_data;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [FWIDTH-1:0] f_out_data;

  // Deselect ends the frame at once; the link clock may stop afterwards,
  // so no frame state may wait for another edge to clear
  assign frame_rst = sys_rst | link_cs_n;

  // Command byte including the bit being sampled now
  assign cmd_full = {lk_reg.cmd[6:0], link_mosi};

  // Constant lookup, no write path exists into the table
  assign rom_data = sfh_rom_byte(lk_reg.rd_addr, VENDOR_ID);

  // Prefetch buffer between table reader and output shifter
  sfh_fifo #(
    .WIDTH(FWIDTH),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .clk(link_sclk),
    .rst(frame_rst),
    .in_valid(lk_reg.rd_go),
    .in_ready(f_in_ready),
    .in_data(rom_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Shifter takes a new byte on the last dummy bit and each byte end
  always_comb
  begin
    f_out_ready = 1'b0;
    if (lk_reg.st == ST_DUMMY && lk_reg.cnt == CNT_DUMMY_LAST)
      f_out_ready = 1'b1;
    else if (lk_reg.st == ST_DATA && lk_reg.bcnt == BIT_LAST)
      f_out_ready = 1'b1;
  end

  // Link frame sequencer
  always_comb
  begin
    lk_next = lk_reg;
    tg_next = tg_reg;
    if (lk_reg.st != ST_DATA && lk_reg.st != ST_IGNORE)
      lk_next.cnt = lk_reg.cnt + 1'b1;
    // Reader fills the buffer and steps through the space
    if (lk_reg.rd_go && f_in_ready)
      lk_next.rd_addr = lk_reg.rd_addr + 24'h00_0001;
    unique case (lk_reg.st)
      ST_CMD:
      begin
        lk_next.cmd = cmd_full;
        if (lk_reg.cnt == CNT_CMD_LAST)
        begin
          // Only the discovery read is served; program, erase and all
          // other codes are dropped and leave the table untouched
          if (cmd_full == CMD_READ_SFDP)
          begin
            lk_next.st = ST_ADDR;
          end
          else
          begin
            lk_next.st = ST_IGNORE;
            tg_next.tgl_ign = ~tg_reg.tgl_ign;
          end
        end
      end
      ST_ADDR:
      begin
        lk_next.addr = {lk_reg.addr[22:0], link_mosi};
        if (lk_reg.cnt == CNT_ADDR_LAST)
        begin
          // Any start address is accepted, zero being the signature
          lk_next.rd_addr = {lk_reg.addr[22:0], link_mosi};
          lk_next.rd_go = 1'b1;
          tg_next.hold_addr = {lk_reg.addr[22:0], link_mosi};
          tg_next.tgl_read = ~tg_reg.tgl_read;
          lk_next.st = ST_DUMMY;
        end
      end
      ST_DUMMY:
      begin
        if (lk_reg.cnt == CNT_DUMMY_LAST)
        begin
          // Buffer was filled during the dummy bits; blank if it was not
          lk_next.sh = f_out_valid ? f_out_data : BLANK_BYTE;
          lk_next.miso = f_out_valid ? f_out_data[7] : BLANK_BYTE[7];
          lk_next.oe = 1'b1;
          lk_next.bcnt = '0;
          lk_next.st = ST_DATA;
        end
      end
      ST_DATA:
      begin
        lk_next.bcnt = lk_reg.bcnt + 1'b1;
        if (lk_reg.bcnt == BIT_LAST)
        begin
          // Next byte follows without a gap
          lk_next.sh = f_out_valid ? f_out_data : BLANK_BYTE;
          lk_next.miso = f_out_valid ? f_out_data[7] : BLANK_BYTE[7];
        end
        else
        begin
          lk_next.sh = {lk_reg.sh[6:0], 1'b0};
          lk_next.miso = lk_reg.sh[6];
        end
      end
      ST_IGNORE:
      begin
        // Output stays released until select goes high
        lk_next.oe = 1'b0;
      end
    endcase
  end

  // Frame registers on the link clock
  always_ff @(posedge link_sclk or posedge frame_rst)
  begin
    if (frame_rst)
      lk_reg <= '0;
    else
      lk_reg <= lk_next;
  end

  // Toggle registers on the link clock, reset only by the system
  always_ff @(posedge link_sclk or posedge sys_rst)
  begin
    if (sys_rst)
      tg_reg <= '0;
    else
      tg_reg <= tg_next;
  end

  // Link outputs come straight from flip-flops
  assign link_miso = lk_reg.miso;
  assign link_miso_oe = lk_reg.oe;

  // Grouped view of the events crossing to the system clock
  assign ev.read_start = sy_reg.rd_sync[1] ^ sy_reg.rd_sync[2];
  assign ev.cmd_ignored = sy_reg.ign_sync[1] ^ sy_reg.ign_sync[2];
  assign ev.start_addr = tg_reg.hold_addr;

  // System side: three flops per level, edge found between the second and third.
  // The held address is stable long before its toggle is seen, since
  // it only changes again a whole address phase later.
  always_comb
  begin
    sy_next = sy_reg;
    sy_next.cs_sync = {sy_reg.cs_sync[1:0], link_cs_n};
    sy_next.rd_sync = {sy_reg.rd_sync[1:0], tg_reg.tgl_read};
    sy_next.ign_sync = {sy_reg.ign_sync[1:0], tg_reg.tgl_ign};
    sy_next.active = ~sy_reg.cs_sync[1];
    sy_next.start = ev.read_start;
    sy_next.ign = ev.cmd_ignored;
    if (ev.read_start)
    begin
      sy_next.addr = ev.start_addr;
      sy_next.count = sy_reg.count + 16'h0001;
    end
  end

  // System registers; select idles high so its chain resets high
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sy_reg <= '0;
      sy_reg.cs_sync <= 3'h7;
    end
    else
      sy_reg <= sy_next;
  end

  // System outputs
  assign read_active = sy_reg.active;
  assign read_start = sy_reg.start;
  assign cmd_ignored = sy_reg.ign;
  assign start_addr = sy_reg.addr;
  assign read_count = sy_reg.count;
endmodule

// ### test/sfh_host_model.sv
`timescale 1ns/1ps
module sfh_host_model (
  // Link outputs
  output logic link_sclk,
  output logic link_cs_n,
  output logic link_mosi,
  // Link inputs
  input wire logic link_miso,
  input wire logic link_miso_oe
);
  logic [7:0] rx [32];
  logic line;

  // Clock stands low outside frames
  initial
  begin
    link_sclk = 1'b0;
    link_cs_n = 1'b1;
    link_mosi = 1'b0;
  end

  // One 12 ns link period; data is set while the clock is low
  task automatic pulse();
    #6 link_sclk = 1'b1;
    #6 link_sclk = 1'b0;
  endtask

  // Frame: command, address, dummy byte, then n bytes MSB first
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] addr, input int n);
    logic [31:0] hdr;
    hdr = {cmd, addr};
    #3 link_cs_n = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      link_mosi = hdr[i];
      pulse();
    end
    for (int i = 0; i < 8 * n + 8; i++)
    begin
      link_mosi = 1'($urandom); // Don't care bits keep changing
      if (i >= 8)
      begin
        // Undriven line shows garbage, never a stale bit
        line = link_miso_oe ? link_miso : ~line;
        rx[(i - 8) / 8] = {rx[(i - 8) / 8][6:0], line};
      end
      pulse();
    end
    #6 link_cs_n = 1'b1;
    link_mosi = ~link_mosi;
  endtask
endmodule

// ### test/sfh_rom_monitor.sv
`timescale 1ns/1ps
module sfh_rom_monitor (
  // System side
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic read_active,
  input wire logic read_start,
  input wire logic cmd_ignored,
  input wire logic [23:0] start_addr,
  input wire logic [15:0] read_count,
  // Link
  input wire logic link_sclk,
  input wire logic link_cs_n,
  input wire logic link_mosi,
  input wire logic link_miso,
  input wire logic link_miso_oe
);
  logic [11:0] edge_reg;
  logic [7:0] cmd_reg;

  // Edge count and command of the frame; cleared like the frame logic
  always_ff @(posedge link_sclk or posedge link_cs_n or posedge sys_rst)
  begin
    if (link_cs_n || sys_rst)
    begin
      edge_reg <= 12'h000;
      cmd_reg <= 8'h00;
    end
    else
    begin
      edge_reg <= (edge_reg == 12'hFFF) ? edge_reg : edge_reg + 12'h001;
      cmd_reg <= (edge_reg < 12'h008) ? {cmd_reg[6:0], link_mosi} : cmd_reg;
    end
  end

  // Link side
  idle_line_a: assert property (@(posedge clk) disable iff (sys_rst)
    link_cs_n |-> !link_miso_oe && !link_miso) else $error("miso driven outside frame");
  quiet_head_a: assert property (@(posedge link_sclk) disable iff (sys_rst || link_cs_n)
    edge_reg < 12'h028 |-> !link_miso_oe) else $error("miso driven before data");
  drive_data_a: assert property (@(posedge link_sclk) disable iff (sys_rst || link_cs_n)
    edge_reg >= 12'h028 && cmd_reg == 8'h5A |-> link_miso_oe)
    else $error("miso not driven in data phase");
  refuse_cmd_a: assert property (@(posedge link_sclk) disable iff (sys_rst || link_cs_n)
    edge_reg >= 12'h008 && cmd_reg != 8'h5A |-> !link_miso_oe)
    else $error("miso driven for other command");
  // System side
  start_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    read_start |=> !read_start) else $error("read_start longer than one cycle");
  ign_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    cmd_ignored |=> !cmd_ignored) else $error("cmd_ignored longer than one cycle");
  count_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    $changed(read_count) |-> read_start && read_count == $past(read_count) + 16'h0001)
    else $error("read_count step wrong");
  addr_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !read_start |-> $stable(start_addr)) else $error("start_addr moved without read");
  active_on_a: assert property (@(posedge clk) disable iff (sys_rst)
    !link_cs_n [*5] |-> read_active) else $error("read_active late");

  // Main scenarios
  read_seen_c: cover property (@(posedge clk) read_start);
  ign_seen_c: cover property (@(posedge clk) cmd_ignored);
  long_read_c: cover property (@(posedge link_sclk) edge_reg == 12'h0F0 && link_miso_oe);
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] TB_VID = 8'h3C; // Arbitrary maker code
  logic clk, sys_rst, link_sclk, link_cs_n, link_mosi, link_miso, link_miso_oe;
  logic read_active, read_start, cmd_ignored;
  logic [23:0] start_addr;
  logic [15:0] read_count;
  logic [7:0] hdr [24];
  int errors = 0;
  int n_compared = 0;
  int n_start = 0;
  int n_ign = 0;
  int x_ign = 0;
  int n_reads = 0;
  int cycles = 0;
  int act_seen = 0;

  sfh_rom #(.VENDOR_ID(TB_VID)) uut (.clk(clk), .sys_rst(sys_rst), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .link_mosi(link_mosi), .link_miso(link_miso),
    .link_miso_oe(link_miso_oe), .read_active(read_active), .read_start(read_start),
    .cmd_ignored(cmd_ignored), .start_addr(start_addr), .read_count(read_count));
  sfh_host_model hst (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_mosi(link_mosi),
    .link_miso(link_miso), .link_miso_oe(link_miso_oe));

  // Expected byte; past the header the space reads blank
  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return (a < 24'h00_0018) ? hdr[a[4:0]] : 8'hFF;
  endfunction

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read frame; gap after it lets the system side catch up
  task automatic rd(input logic [23:0] a, input int n);
    hst.xfer(8'h5A, a, n);
    n_reads++;
    repeat (10) @(negedge clk);
    for (int i = 0; i < n; i++)
      chk_byte("rx byte", exp_byte(a + 24'(i)), hst.rx[i]);
    chk_word("start_addr", a, start_addr);
    chk_word("read_count", 24'(n_reads), {8'h00, read_count});
    chk_word("read pulses", 24'(n_reads), 24'(n_start));
    chk_word("read_active idle", 24'h00_0000, {23'h00_0000, read_active});
    chk_word("read_active seen", 24'h00_0001, 24'(act_seen));
    act_seen = 0;
  endtask

  // Refused frame with random payload after the address
  task automatic bad(input logic [7:0] c);
    hst.xfer(c, 24'($urandom_range(23, 0)), 2);
    x_ign++;
    repeat (10) @(negedge clk);
    chk_word("ignored", 24'(x_ign), 24'(n_ign));
    chk_word("read_count", 24'(n_reads), {8'h00, read_count});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulse counts and hang guard; a full run needs about 800 cycles.
  // Falling edge, so outputs launched on the rising edge have settled
  always @(negedge clk)
  begin
    cycles++;
    if (read_start === 1'b1) n_start++;
    if (cmd_ignored === 1'b1) n_ign++;
    if (read_active === 1'b1) act_seen = 1;
    if (cycles == 20000)
    begin
      errors++;
      $display("CHECK FAILED timeout exp done got hang");
      summarize();
    end
  end

  initial
  begin
    logic [7:0] c;
    hdr = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h08, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h07, 8'h01,
      8'h10, 8'h30, 8'h00, 8'h00, 8'hFF, TB_VID, 8'h00, 8'h01, 8'h03, 8'h70, 8'h00,
      8'h00, 8'hFF};
    sys_rst = 1'b0;
    void'($urandom(32'h9a06c584));
    #1 sys_rst = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    // Whole header and blank bytes after it
    rd(24'h00_0000, 26);
    for (int i = 0; i < 8; i++)
      chk_byte("hdr", exp_byte(24'(i)), hst.rx[i]);
    for (int i = 8; i < 16; i++)
      chk_byte("hdr", exp_byte(24'(i)), hst.rx[i]);
    for (int i = 16; i < 24; i++)
      chk_byte("hdr", exp_byte(24'(i)), hst.rx[i]);
    $display("test header done");
    // Corners: last header byte, wrap of the 24-bit address
    rd(24'h00_0017, 2);
    rd(24'hFF_FFFE, 4);
    repeat (10)
      rd(24'($urandom_range(31, 0)), $urandom_range(8, 1));
    $display("test random reads done");
    // Program, erase and random commands change nothing
    foreach (hdr[i])
      if (i < 4) bad(i == 0 ? 8'h02 : i == 1 ? 8'h20 : i == 2 ? 8'hD8 : 8'h06);
    repeat (4)
    begin
      c = 8'($urandom);
      bad(c == 8'h5A ? 8'h5B : c);
    end
    rd(24'h00_0000, 24);
    $display("test refused done");
    summarize();
  end
endmodule

bind sfh_rom sfh_rom_monitor mon (.clk(clk), .sys_rst(sys_rst), .read_active(read_active),
  .read_start(read_start), .cmd_ignored(cmd_ignored), .start_addr(start_addr),
  .read_count(read_count), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
  .link_mosi(link_mosi), .link_miso(link_miso), .link_miso_oe(link_miso_oe));
